//--- design/smt_stack_xfer.sv
// module: sequencer for stack multiple load and store instructions
//
// Overview of operation
// - load from stack fills any of r0-r12 plus program counter or link
// - loaded program counter word with bit 0 clear raises usage error
// - narrow load mask: pc bit at 15, seven zeros, 8-bit list
// - narrow load unpredictable if mask empty or pc inside block mid-slot
// - wide load mask pc, lr, zero, 13-bit list; <2 or both bad
// - registers move ascending, lowest register at lowest address
// - load starts at sp, sp grows by four per register, pc last
// - loading the program counter branches to the loaded address
// - store to stack writes any of r0-r12 plus optional link register
// - narrow store mask: zero, lr at 14, six zeros, 8-bit list
// - wide store mask zero, lr, zero, 13-bit list; fewer than 2 bad
// - single-register store selects one, unaligned ok, 13 or 15 bad
// - store starts at sp minus four per register, then lowers sp
// - failed condition check leaves all state untouched
module smt_stack_xfer
	import smt_pkg::*;
(
	input  wire logic        clk_i,                   // core clock
	input  wire logic        rst_i,                   // async reset, high
	input  wire logic        instr_valid_i,           // instruction offered
	input  wire logic [31:0] instr_i,                 // instruction bits
	input  wire logic        instr_wide_i,            // 32-bit encoding
	input  wire logic        cond_pass_i,             // condition check passed
	input  wire logic        in_cond_block_i,         // inside cond block
	input  wire logic        last_in_cond_block_i,    // last slot of block
	input  wire logic [31:0] sp_i,                    // current stack pointer
	output logic      [3:0]  reg_rd_idx_o,            // register read index
	input  wire logic [31:0] reg_rd_data_i,           // register read data
	output logic             reg_wr_en_o,             // register write pulse
	output logic      [3:0]  reg_wr_idx_o,            // register write index
	output logic      [31:0] reg_wr_data_o,           // register write data
	output logic             sp_wr_en_o,              // stack pointer write
	output logic      [31:0] sp_wr_data_o,            // new stack pointer
	output logic             mem_req_o,               // word access request
	output logic             mem_we_o,                // 1 store, 0 load
	output logic      [31:0] mem_addr_o,              // word address
	output logic      [31:0] mem_wdata_o,             // store data
	output logic             misalign_permit_o,       // unaligned allowed
	input  wire logic        mem_ack_i,               // access complete
	input  wire logic [31:0] mem_rdata_i,             // load data
	output logic             pc_write_from_load_o,    // branch pulse
	output logic      [31:0] branch_target_o,         // branch address
	output logic             usage_error_exception_o, // bad pc bit 0 pulse
	output logic             undef_fault_o,           // unpredictable pulse
	output logic             claim_o,                 // encoding recognised
	output logic             busy_o,                  // sequence running
	output logic             done_o                   // instruction retired
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ISSUE = 4'b0010,
		ST_WAIT  = 4'b0100,
		ST_DONE  = 4'b1000
	} smt_state_t;

	smt_dec_t    dec;
	smt_state_t  state_q;
	smt_state_t  state_d;
	logic        start;
	logic        go;
	logic        op_load_q;
	logic [15:0] mask_q;
	logic [4:0]  cnt_q;
	logic [4:0]  xfer_cnt_q;
	logic [31:0] base_sp_q;
	logic [31:0] first_addr_q;
	logic [31:0] addr_q;
	logic [3:0]  cur_idx;
	logic [4:0]  dec_cnt;
	logic [31:0] dec_bytes;
	logic        last_word;

	smt_decode u_decode (
		.instr_i              (instr_i),
		.wide_i               (instr_wide_i),
		.in_cond_block_i      (in_cond_block_i),
		.last_in_cond_block_i (last_in_cond_block_i),
		.dec_o                (dec)
	);

	// lowest register still to move
	function automatic logic [3:0] smt_lowest(input logic [15:0] m);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--)
		begin
			if (m[i])
			begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	assign claim_o      = instr_valid_i && dec.hit;
	assign start        = claim_o && (state_q == ST_IDLE);
	assign go           = start && cond_pass_i && !dec.unpred;
	assign busy_o       = state_q != ST_IDLE;
	assign cur_idx      = smt_lowest(mask_q);
	assign reg_rd_idx_o = cur_idx;
	assign dec_cnt      = smt_popcount(dec.mask);
	assign dec_bytes    = {25'h0, dec_cnt, 2'b00};
	assign last_word    = (mask_q & ~(16'h0001 << cur_idx)) == 16'h0000;

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:  if (go) state_d = ST_ISSUE;
			ST_ISSUE: state_d = ST_WAIT;
			ST_WAIT:  if (mem_ack_i) state_d = last_word ? ST_DONE : ST_ISSUE;
			ST_DONE:  state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_IDLE;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// operand capture and address walk
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			op_load_q         <= 1'b0;
			mask_q            <= 16'h0000;
			cnt_q             <= 5'h00;
			xfer_cnt_q        <= 5'h00;
			base_sp_q         <= RST_WORD;
			first_addr_q      <= RST_WORD;
			addr_q            <= RST_WORD;
			misalign_permit_o <= 1'b0;
		end
		else if (go)
		begin
			op_load_q         <= dec.is_load;
			mask_q            <= dec.mask;
			cnt_q             <= dec_cnt;
			xfer_cnt_q        <= 5'h00;
			base_sp_q         <= sp_i;
			misalign_permit_o <= dec.misalign_permit;
			// a load reads upward from sp, a store fills the block below it
			if (dec.is_load)
			begin
				first_addr_q <= sp_i;
				addr_q       <= sp_i;
			end
			else
			begin
				first_addr_q <= sp_i - dec_bytes;
				addr_q       <= sp_i - dec_bytes;
			end
		end
		else if (state_q == ST_WAIT && mem_ack_i)
		begin
			mask_q     <= mask_q & ~(16'h0001 << cur_idx);
			addr_q     <= addr_q + 32'h0000_0004;
			xfer_cnt_q <= xfer_cnt_q + 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// memory access
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mem_req_o   <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_addr_o  <= RST_WORD;
			mem_wdata_o <= RST_WORD;
		end
		else if (state_q == ST_ISSUE)
		begin
			mem_req_o   <= 1'b1;
			mem_we_o    <= !op_load_q;
			mem_addr_o  <= addr_q;
			mem_wdata_o <= reg_rd_data_i;
		end
		else if (mem_ack_i)
		begin
			mem_req_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// load write-back and branch
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			reg_wr_en_o             <= 1'b0;
			reg_wr_idx_o            <= 4'h0;
			reg_wr_data_o           <= RST_WORD;
			pc_write_from_load_o    <= 1'b0;
			branch_target_o         <= RST_WORD;
			usage_error_exception_o <= 1'b0;
		end
		else
		begin
			reg_wr_en_o             <= 1'b0;
			pc_write_from_load_o    <= 1'b0;
			usage_error_exception_o <= 1'b0;
			if (state_q == ST_WAIT && mem_ack_i && op_load_q)
			begin
				// pc is bit 15, so it always comes out of the walk last
				if (cur_idx == REG_PC)
				begin
					if (mem_rdata_i[0])
					begin
						pc_write_from_load_o <= 1'b1;
						branch_target_o      <= {mem_rdata_i[31:1], 1'b0};
					end
					else
					begin
						usage_error_exception_o <= 1'b1;
					end
				end
				else
				begin
					reg_wr_en_o   <= 1'b1;
					reg_wr_idx_o  <= cur_idx;
					reg_wr_data_o <= mem_rdata_i;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// stack pointer update, retire and faults
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sp_wr_en_o    <= 1'b0;
			sp_wr_data_o  <= RST_WORD;
			done_o        <= 1'b0;
			undef_fault_o <= 1'b0;
		end
		else
		begin
			sp_wr_en_o    <= 1'b0;
			done_o        <= 1'b0;
			undef_fault_o <= 1'b0;
			if (state_q == ST_DONE)
			begin
				sp_wr_en_o <= 1'b1;
				done_o     <= 1'b1;
				if (op_load_q)
				begin
					sp_wr_data_o <= base_sp_q + {25'h0, cnt_q, 2'b00};
				end
				else
				begin
					sp_wr_data_o <= base_sp_q - {25'h0, cnt_q, 2'b00};
				end
			end
			else if (start && !cond_pass_i)
			begin
				done_o <= 1'b1;
			end
			else if (start && dec.unpred)
			begin
				undef_fault_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_narrow_load_mask: assert property (
		start && !instr_wide_i && dec.is_load |-> dec.mask[14:8] == 7'h00)
		else $error("narrow load mask has stray bits");
	chk_wide_load_bad: assert property (
		start && instr_wide_i && dec.is_load && dec.mask[15] && dec.mask[14]
		|-> dec.unpred)
		else $error("pc and lr together not flagged");
	chk_unpred_fault: assert property (
		start && cond_pass_i && dec.unpred |=> undef_fault_o && !busy_o)
		else $error("unpredictable encoding did not fault");
	chk_cond_fail_quiet: assert property (
		start && !cond_pass_i |=> done_o && !busy_o && !mem_req_o
		##1 !sp_wr_en_o)
		else $error("failed condition changed state");
	chk_addr_ascend: assert property (
		mem_req_o |-> mem_addr_o == first_addr_q + {25'h0, xfer_cnt_q, 2'b00})
		else $error("access address out of order");
	chk_load_sp_step: assert property (
		sp_wr_en_o && op_load_q |->
		sp_wr_data_o == first_addr_q + {25'h0, cnt_q, 2'b00})
		else $error("load stack pointer step wrong");
	chk_store_sp_end: assert property (
		sp_wr_en_o && !op_load_q |-> sp_wr_data_o == first_addr_q)
		else $error("store stack pointer not lowered to block base");
	chk_pc_bit0_fault: assert property (
		state_q == ST_WAIT && mem_ack_i && op_load_q && cur_idx == REG_PC
		&& !mem_rdata_i[0] |=> usage_error_exception_o && !pc_write_from_load_o)
		else $error("bad pc bit 0 not reported");
	chk_branch_taken: assert property (
		state_q == ST_WAIT && mem_ack_i && op_load_q && cur_idx == REG_PC
		&& mem_rdata_i[0] |=> pc_write_from_load_o
		&& branch_target_o == {$past(mem_rdata_i[31:1]), 1'b0} ##1 sp_wr_en_o)
		else $error("pc load did not branch");
	chk_store_no_wb: assert property (
		busy_o && !op_load_q |-> !reg_wr_en_o && !pc_write_from_load_o)
		else $error("store wrote a register");

	cov_load_branch: cover property (pc_write_from_load_o);
	cov_store_multi: cover property (sp_wr_en_o && !op_load_q && cnt_q > 5'h01);
	cov_usage_fault: cover property (usage_error_exception_o);
	cov_unpred:      cover property (undef_fault_o);

endmodule

//--- design/smt_pkg.sv
// package: shared constants, decode carrier and helpers for stack transfers
package smt_pkg;

	// ----------------------------------------------------------------
	// register numbers
	// ----------------------------------------------------------------
	localparam logic [3:0]  REG_SP        = 4'hD;
	localparam logic [3:0]  REG_LR        = 4'hE;
	localparam logic [3:0]  REG_PC        = 4'hF;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [6:0]  OPC16_LOAD    = 7'h5E;
	localparam logic [6:0]  OPC16_STORE   = 7'h5A;
	localparam logic [15:0] OPC32_LOADM   = 16'hE8BD;
	localparam logic [15:0] OPC32_STOREM  = 16'hE92D;
	localparam logic [15:0] OPC32_LOAD1   = 16'hF85D;
	localparam logic [15:0] OPC32_STORE1  = 16'hF84D;
	localparam logic [11:0] SUF32_LOAD1   = 12'hB04;
	localparam logic [11:0] SUF32_STORE1  = 12'hD04;

	// ----------------------------------------------------------------
	// counts and reset values
	// ----------------------------------------------------------------
	localparam logic [4:0]  MIN_CNT_NARROW = 5'h01;
	localparam logic [4:0]  MIN_CNT_MULTI  = 5'h02;
	localparam logic [31:0] RST_WORD       = 32'h0000_0000;

	typedef struct packed {
		logic        hit;
		logic        is_load;
		logic [15:0] mask;
		logic        misalign_permit;
		logic        unpred;
	} smt_dec_t;

	// number of selected registers
	function automatic logic [4:0] smt_popcount(input logic [15:0] m);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < 16; i++)
		begin
			c = c + {4'h0, m[i]};
		end
		return c;
	endfunction

endpackage

//--- design/smt_decode.sv
// module: mask and fault decode for the six stack transfer encodings
module smt_decode
	import smt_pkg::*;
(
	input  wire logic [31:0] instr_i,             // first halfword high
	input  wire logic        wide_i,              // 32-bit encoding
	input  wire logic        in_cond_block_i,     // inside conditional block
	input  wire logic        last_in_cond_block_i, // last slot of block
	output smt_dec_t         dec_o                // decode result
);

	logic [15:0] hw1;
	logic [15:0] hw2;
	logic        it_bad;
	logic [3:0]  t;

	assign hw1    = instr_i[31:16];
	assign hw2    = instr_i[15:0];
	assign it_bad = in_cond_block_i && !last_in_cond_block_i;
	assign t      = hw2[15:12];

	always_comb
	begin
		dec_o = '0;
		if (!wide_i)
		begin
			if (hw2[15:9] == OPC16_LOAD)
			begin
				dec_o.hit     = 1'b1;
				dec_o.is_load = 1'b1;
				dec_o.mask    = {hw2[8], 7'h00, hw2[7:0]};
				dec_o.unpred  = (smt_popcount(dec_o.mask) < MIN_CNT_NARROW)
					|| (dec_o.mask[15] && it_bad);
			end
			else if (hw2[15:9] == OPC16_STORE)
			begin
				dec_o.hit    = 1'b1;
				dec_o.mask   = {1'b0, hw2[8], 6'h00, hw2[7:0]};
				dec_o.unpred = smt_popcount(dec_o.mask) < MIN_CNT_NARROW;
			end
		end
		else if (hw1 == OPC32_LOADM)
		begin
			dec_o.hit     = 1'b1;
			dec_o.is_load = 1'b1;
			// reserved bit 13 is forced clear, so the stack pointer never loads
			dec_o.mask    = {hw2[15], hw2[14], 1'b0, hw2[12:0]};
			dec_o.unpred  = (smt_popcount(dec_o.mask) < MIN_CNT_MULTI)
				|| (hw2[15] && hw2[14])
				|| (dec_o.mask[15] && it_bad);
		end
		else if (hw1 == OPC32_STOREM)
		begin
			dec_o.hit    = 1'b1;
			dec_o.mask   = {1'b0, hw2[14], 1'b0, hw2[12:0]};
			dec_o.unpred = smt_popcount(dec_o.mask) < MIN_CNT_MULTI;
		end
		else if (hw1 == OPC32_LOAD1 && hw2[11:0] == SUF32_LOAD1)
		begin
			dec_o.hit             = 1'b1;
			dec_o.is_load         = 1'b1;
			dec_o.mask            = 16'h0001 << t;
			dec_o.misalign_permit = 1'b1;
			dec_o.unpred          = (t == REG_SP)
				|| (t == REG_PC && it_bad);
		end
		else if (hw1 == OPC32_STORE1 && hw2[11:0] == SUF32_STORE1)
		begin
			dec_o.hit             = 1'b1;
			dec_o.mask            = 16'h0001 << t;
			dec_o.misalign_permit = 1'b1;
			dec_o.unpred          = (t == REG_SP) || (t == REG_PC);
		end
	end

endmodule

//--- tb/smt_mem_model.sv
// memory model that answers word accesses after a selectable wait
module smt_mem_model (
	input  wire logic        clk_i,   // core clock
	input  wire logic        rst_i,   // async reset, high
	input  wire logic        req_i,   // access request
	input  wire logic [31:0] addr_i,  // word address
	input  wire logic [2:0]  wait_i,  // cycles before ack
	input  wire logic        flip_i,  // invert bit 0 of load data
	output logic             ack_o,   // access complete
	output logic      [31:0] rdata_o  // load data
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] cnt_q;

	// ----------------------------------------------------------------
	// wait counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cnt_q <= 3'h0;
		else if (ack_o)
			cnt_q <= 3'h0;
		else if (req_i)
			cnt_q <= cnt_q + 3'h1;
	end

	assign ack_o = req_i && (cnt_q >= wait_i);
	// outside ack the bus shows the address, so data taken early is wrong
	assign rdata_o = ack_o ? (~addr_i ^ {31'h0, flip_i}) : addr_i;
endmodule

//--- tb/smt_stack_xfer_bench.sv
// testbench for the stack multiple load and store sequencer
module smt_stack_xfer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import smt_pkg::*;

	logic        clk_i, rst_i, valid, wide, cond, incb, last;
	logic [31:0] instr, sp, rd_data, mem_rdata;
	logic [3:0]  rd_idx, wr_idx;
	logic [31:0] wr_data, sp_data, addr, wdata, br_tgt;
	logic        wr_en, sp_en, req, we, mp, ack, br, use_err, undef, done;
	logic        claim, busy;
	logic [2:0]  mem_wait;
	logic        mem_flip;
	logic [31:0] ma[$], md[$], rdq[$];
	logic [1:0]  mf[$];
	logic [3:0]  ri[$];
	logic [31:0] br_t, sp_d;
	int          n_br, n_use, n_sp, n_done, n_undef;
	int          n_busy, n_claim;
	int          failures, checked;

	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	smt_stack_xfer dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(valid),
		.instr_i(instr), .instr_wide_i(wide), .cond_pass_i(cond),
		.in_cond_block_i(incb), .last_in_cond_block_i(last), .sp_i(sp),
		.reg_rd_idx_o(rd_idx), .reg_rd_data_i(rd_data),
		.reg_wr_en_o(wr_en), .reg_wr_idx_o(wr_idx),
		.reg_wr_data_o(wr_data), .sp_wr_en_o(sp_en),
		.sp_wr_data_o(sp_data), .mem_req_o(req), .mem_we_o(we),
		.mem_addr_o(addr), .mem_wdata_o(wdata), .misalign_permit_o(mp),
		.mem_ack_i(ack), .mem_rdata_i(mem_rdata),
		.pc_write_from_load_o(br), .branch_target_o(br_tgt),
		.usage_error_exception_o(use_err), .undef_fault_o(undef),
		.claim_o(claim), .busy_o(busy), .done_o(done)
	);

	smt_mem_model mem_u (
		.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .addr_i(addr),
		.wait_i(mem_wait), .flip_i(mem_flip), .ack_o(ack),
		.rdata_o(mem_rdata)
	);

	// register file: each register holds a value naming itself
	assign rd_data = {28'hC000000, rd_idx};

	// ----------------------------------------------------------------
	// monitors
	// ----------------------------------------------------------------
	always @(posedge clk_i)
	begin
		if (req && ack)
		begin
			ma.push_back(addr);
			md.push_back(wdata);
			mf.push_back({we, mp});
		end
		if (wr_en)
		begin
			ri.push_back(wr_idx);
			rdq.push_back(wr_data);
		end
		if (br)
		begin
			n_br++;
			br_t = br_tgt;
		end
		if (sp_en)
		begin
			n_sp++;
			sp_d = sp_data;
		end
		n_use += use_err;
		n_done += done;
		n_undef += undef;
		n_busy += busy;
		n_claim += claim;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic end_sim;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic run(input logic [31:0] ins, input logic w,
		input logic c, input logic ib, input logic lb,
		input logic [31:0] s);
		ma.delete(); md.delete(); mf.delete(); ri.delete(); rdq.delete();
		n_br = 0; n_use = 0; n_sp = 0; n_done = 0; n_undef = 0;
		n_busy = 0; n_claim = 0;
		@(negedge clk_i);
		instr = ins; wide = w; cond = c; incb = ib; last = lb; sp = s;
		valid = 1'b1;
		@(negedge clk_i);
		valid = 1'b0;
		for (int k = 0; k < 300 && n_done == 0 && n_undef == 0; k++)
			@(negedge clk_i);
		repeat (2) @(negedge clk_i);
		chk("claim", 32'h1, 32'(n_claim));
	endtask

	task automatic expect_xfer(input string nm, input logic [15:0] m,
		input logic ld, input logic pm, input logic [31:0] s);
		int n;
		int k;
		logic [31:0] a;
		n = 0;
		for (int i = 0; i < 16; i++)
			n += m[i];
		a = ld ? s : s - 32'(4 * n);
		chk({nm, " accesses"}, 32'(n), 32'(ma.size()));
		chk({nm, " writebacks"}, ld ? 32'(n - m[15]) : 32'h0,
			32'(ri.size()));
		k = 0;
		for (int i = 0; i < 16; i++)
			if (m[i] && k < ma.size())
			begin
				chk({nm, " address"}, a, ma[k]);
				chk({nm, " kind"}, {30'h0, !ld, pm}, {30'h0, mf[k]});
				if (!ld)
					chk({nm, " store data"}, {28'hC000000, i[3:0]}, md[k]);
				else if (i < 15 && k < ri.size())
				begin
					chk({nm, " load index"}, 32'(i), {28'h0, ri[k]});
					chk({nm, " load data"}, ~a ^ {31'h0, mem_flip},
						rdq[k]);
				end
				else if (i == 15)
				begin
					chk({nm, " usage error"}, 32'(mem_flip), 32'(n_use));
					chk({nm, " branch"}, 32'(!mem_flip), 32'(n_br));
					if (!mem_flip)
						chk({nm, " target"}, ~a & 32'hFFFFFFFE, br_t);
				end
				a = a + 32'h4;
				k++;
			end
		chk({nm, " sp writes"}, 32'h1, 32'(n_sp));
		chk({nm, " new sp"}, ld ? s + 32'(4 * n) : s - 32'(4 * n), sp_d);
		chk({nm, " retired"}, 32'h1, 32'(n_done));
		// one issue cycle and wait-plus-one cycles per word, then retire
		chk({nm, " busy cycles"}, 32'(n * (mem_wait + 2) + 1),
			32'(n_busy));
		$display("test %s done", nm);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_loads;
		mem_wait = 3'h0;
		run(32'h0000BD09, 1'b0, 1'b1, 1'b0, 1'b0, 32'h20001000);
		expect_xfer("narrow load", 16'h8009, 1'b1, 1'b0, 32'h20001000);
		mem_wait = 3'h3;
		run(32'hE8BD5FFF, 1'b1, 1'b1, 1'b0, 1'b0, 32'h20002000);
		expect_xfer("wide load lr", 16'h5FFF, 1'b1, 1'b0, 32'h20002000);
		run(32'hE8BD8003, 1'b1, 1'b1, 1'b1, 1'b1, 32'h20002100);
		expect_xfer("wide load pc", 16'h8003, 1'b1, 1'b0, 32'h20002100);
		mem_wait = 3'h1;
		run(32'hF85DFB04, 1'b1, 1'b1, 1'b1, 1'b1, 32'h20003002);
		expect_xfer("single load", 16'h8000, 1'b1, 1'b1, 32'h20003002);
		mem_flip = 1'b1;
		run(32'h0000BD80, 1'b0, 1'b1, 1'b0, 1'b0, 32'h20004000);
		expect_xfer("bad pc bit", 16'h8080, 1'b1, 1'b0, 32'h20004000);
		mem_flip = 1'b0;
	endtask

	task automatic t_stores;
		mem_wait = 3'h0;
		run(32'h0000B5F0, 1'b0, 1'b1, 1'b0, 1'b0, 32'h20005000);
		expect_xfer("narrow store", 16'h40F0, 1'b0, 1'b0, 32'h20005000);
		mem_wait = 3'h2;
		run(32'hE92D1003, 1'b1, 1'b1, 1'b0, 1'b0, 32'h20006000);
		expect_xfer("wide store", 16'h1003, 1'b0, 1'b0, 32'h20006000);
		run(32'hF84DED04, 1'b1, 1'b1, 1'b0, 1'b0, 32'h20007006);
		expect_xfer("single store", 16'h4000, 1'b0, 1'b1, 32'h20007006);
	endtask

	// top nibble holds wide, in-block and last-slot flags
	task automatic t_unpred;
		logic [35:0] tbl [12];
		tbl = '{36'h0_0000BC00, 36'h4_0000BD01, 36'h8_E8BD0001,
			36'h8_E8BDC003, 36'hC_E8BD8003, 36'h8_F85DDB04,
			36'hC_F85DFB04, 36'h0_0000B400, 36'h8_E92D0002,
			36'h8_F84DDD04, 36'h8_F84DFD04, 36'h8_E92D4000};
		mem_wait = 3'h0;
		foreach (tbl[e])
		begin
			run(tbl[e][31:0], tbl[e][35], 1'b1, tbl[e][34], tbl[e][33],
				32'h20008000);
			chk("fault", 32'h1, 32'(n_undef));
			chk("fault retire", 32'h0, 32'(n_done));
			chk("fault accesses", 32'h0, 32'(ma.size() + n_sp));
			chk("fault busy", 32'h0, 32'(n_busy));
		end
		$display("test unpredictable done");
	endtask

	// a failed condition wins even over an unpredictable encoding
	task automatic t_cond_fail;
		logic [31:0] ins [2];
		ins = '{32'h0000BD09, 32'h0000BC00};
		foreach (ins[e])
		begin
			run(ins[e], 1'b0, 1'b0, 1'b0, 1'b0, 32'h20009000);
			chk("skip retire", 32'h1, 32'(n_done));
			chk("skip fault", 32'h0, 32'(n_undef));
			chk("skip effects", 32'h0,
				32'(ma.size() + ri.size() + n_sp + n_br));
			chk("skip busy", 32'h0, 32'(n_busy));
		end
		$display("test condition fail done");
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		failures = 0; checked = 0;
		rst_i = 1'b1; valid = 1'b0; instr = 32'h0; wide = 1'b0;
		cond = 1'b1; incb = 1'b0; last = 1'b0; sp = 32'h0;
		mem_wait = 3'h0; mem_flip = 1'b0;
		repeat (10) @(negedge clk_i);
		rst_i = 1'b0;
		t_loads();
		t_stores();
		t_unpred();
		t_cond_fail();
		end_sim();
	end

	// the whole run needs well under 3000 cycles
	initial
	begin
		repeat (30000) @(posedge clk_i);
		failures++;
		end_sim();
	end
endmodule
